// ---- pkg/cise_pkg.sv ----
// package for the cpu instruction subset executor: encodings, phases, bus structs
package cise_pkg;
   // opcode fields, instruction bits 15:8 unless noted
   localparam logic [5:0] OP_INC_SKIP_NZ = 6'h13; // 0100 11da
   localparam logic [5:0] OP_OR_FILE = 6'h04;     // 0001 00da
   localparam logic [5:0] OP_MOVE_FILE = 6'h14;   // 0101 00da
   localparam logic [6:0] OP_STORE_ACC = 7'h37;   // 0110 111a
   localparam logic [6:0] OP_MUL_FILE = 7'h01;    // 0000 001a
   localparam logic [7:0] OP_OR_LIT = 8'h09;
   localparam logic [7:0] OP_LOAD_BANK = 8'h01;
   localparam logic [7:0] OP_LOAD_ACC = 8'h0e;
   localparam logic [7:0] OP_MUL_LIT = 8'h0d;
   localparam logic [7:0] OP_LOAD_PTR = 8'hee;    // 1110 1110 00ff kkkk
   localparam logic [3:0] OP_MOVE_FF = 4'hc;      // 1100 ssss...
   localparam logic [3:0] OP_SECOND_WORD = 4'hf;  // 1111 xxxx...
   localparam logic [7:0] INDEXED_LIMIT = 8'h5f;  // indexed offsets 0..95
   localparam logic [11:0] ACC_ADDR = 12'hfe8;    // accumulator in data space
   localparam logic [11:0] ACCESS_SFR_BASE = 12'hf00;
   localparam logic [7:0] ACCESS_SPLIT = 8'h60;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [1:0] POINTER_COUNT = 2'h3;

   // phases of one instruction cycle
   typedef enum logic [3:0] {
      PH_DECODE = 4'h1,
      PH_READ = 4'h2,
      PH_PROCESS = 4'h4,
      PH_WRITE = 4'h8
   } cise_phase_t;

   // data memory request towards the register file
   typedef struct packed {
      logic rd;
      logic wr;
      logic [11:0] addr;
      logic [7:0] wdata;
   } cise_mem_req_t;

   // status flags touched by this subset
   typedef struct packed {
      logic neg;
      logic zero;
   } cise_flags_t;
endpackage

// ---- logic/cise_core.sv ----
// executes a subset of 8-bit cpu instructions in four-phase cycles
`timescale 1ns/1ps
module cise_core
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic instrValid,
   input wire logic [15:0] instrWord,
   input wire logic extendedEnable,
   input wire logic [7:0] memRdata,
   input wire logic [11:0] pointer2Base,
   output cise_pkg::cise_mem_req_t memReq,
   output logic instrTaken,
   output logic [7:0] accumulator,
   output logic [7:0] bankSelect,
   output logic [7:0] productHigh,
   output logic [7:0] productLow,
   output cise_pkg::cise_flags_t flags,
   output logic [35:0] pointerRegs,
   output logic [1:0] skipCount
);

   // -----------------------------------------------------------------
   // decode helpers
   // -----------------------------------------------------------------
   // effective address of a byte-oriented operand: banked, indexed or access
   function automatic logic [11:0] effAddr(input logic [15:0] iw, input logic [7:0] bank_select_reg,
      input logic ext, input logic [11:0] base);
      logic [11:0] res;
      res = 12'h000;
      if (iw[8])
         res = {bank_select_reg[3:0], iw[7:0]};
      else if (ext && iw[7:0] <= cise_pkg::INDEXED_LIMIT)
         res = base + {4'h0, iw[7:0]};
      else if (iw[7:0] < cise_pkg::ACCESS_SPLIT)
         res = {4'h0, iw[7:0]};
      else
         res = cise_pkg::ACCESS_SFR_BASE | {4'h0, iw[7:0]};
      return res;
   endfunction

   // true for the first word of any two-word instruction
   function automatic logic isTwoWord(input logic [15:0] iw);
      return iw[15:12] == cise_pkg::OP_MOVE_FF || iw[15:8] == cise_pkg::OP_LOAD_PTR;
   endfunction

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   cise_pkg::cise_phase_t phase_reg, phase_next;
   logic [15:0] instr_reg;
   logic secondCycle_reg;
   logic [11:0] srcAddr_reg;
   logic [7:0] operand_reg;
   logic [7:0] result_reg;
   logic pairIsPtr_reg;
   logic [1:0] skip_reg;
   logic [11:0] opAddr;
   logic [7:0] accSrc;
   logic resZero;
   logic [15:0] product;
   logic [15:0] curWord;
   logic [7:0] fileResult;

   // reads leave on the decode edge, so they decode the word being taken, not the last one
   assign curWord = (phase_reg == cise_pkg::PH_DECODE) ? (instrValid ? instrWord : 16'h0000)
      : instr_reg;
   assign opAddr = effAddr(curWord, bankSelect, extendedEnable, pointer2Base);
   // accumulator lives in data space too, so read it locally
   assign accSrc = (srcAddr_reg == cise_pkg::ACC_ADDR) ? accumulator : memRdata;
   assign resZero = (result_reg == 8'h00);
   assign product = accumulator * operand_reg;
   assign fileResult = (instr_reg[15:10] == cise_pkg::OP_INC_SKIP_NZ) ? memRdata + 8'h01
      : (instr_reg[15:10] == cise_pkg::OP_OR_FILE) ? accumulator | memRdata
      : memRdata; // write data must be ready on the same edge as the write strobe

   // -----------------------------------------------------------------
   // phase sequencing
   // -----------------------------------------------------------------
   // four phases per cycle, decode first
   always_comb
   begin
      unique case (phase_reg)
         cise_pkg::PH_DECODE: phase_next = cise_pkg::PH_READ;
         cise_pkg::PH_READ: phase_next = cise_pkg::PH_PROCESS;
         cise_pkg::PH_PROCESS: phase_next = cise_pkg::PH_WRITE;
         cise_pkg::PH_WRITE: phase_next = cise_pkg::PH_DECODE;
         default: phase_next = cise_pkg::PH_DECODE;
      endcase
   end

   always_ff @(posedge sys_clk)
   begin
      if (rst)
         phase_reg <= cise_pkg::PH_DECODE;
      else
         phase_reg <= phase_next;
   end

   // instruction word is taken at decode only
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         instr_reg <= 16'h0000;
         instrTaken <= 1'b0;
      end
      else
      begin
         instrTaken <= phase_reg == cise_pkg::PH_DECODE && instrValid;
         if (phase_reg == cise_pkg::PH_DECODE)
            instr_reg <= instrValid ? instrWord : 16'h0000; // nop when nothing fetched
      end
   end

   // -----------------------------------------------------------------
   // skip and two-cycle tracking
   // -----------------------------------------------------------------
   // skip counter: each pending slot turns the next fetched word into a nop
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         skip_reg <= 2'h0;
         secondCycle_reg <= 1'b0;
      end
      else if (phase_reg == cise_pkg::PH_WRITE)
      begin
         if (skip_reg != 2'h0)
         begin
            // a discarded two-word head also discards its tail
            if (skip_reg == 2'h1 && isTwoWord(instr_reg) && !secondCycle_reg)
               skip_reg <= 2'h1;
            else
               skip_reg <= skip_reg - 2'h1;
            secondCycle_reg <= 1'b0;
         end
         else if (secondCycle_reg)
            secondCycle_reg <= 1'b0;
         else if (isTwoWord(instr_reg))
            secondCycle_reg <= 1'b1;
         else if (instr_reg[15:10] == cise_pkg::OP_INC_SKIP_NZ && !resZero)
            skip_reg <= 2'h1;
      end
   end
   assign skipCount = skip_reg;

   // -----------------------------------------------------------------
   // operand read and processing
   // -----------------------------------------------------------------
   // literal operand capture in read phase, file operand capture and compute in process phase
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         operand_reg <= cise_pkg::RESET_BYTE;
         result_reg <= cise_pkg::RESET_BYTE;
         srcAddr_reg <= 12'h000;
         pairIsPtr_reg <= 1'b0;
      end
      else if (phase_reg == cise_pkg::PH_READ && skip_reg == 2'h0 && !secondCycle_reg)
      begin
         if (instr_reg[15:12] == cise_pkg::OP_MOVE_FF)
            srcAddr_reg <= instr_reg[11:0];
         else if (instr_reg[15:8] == cise_pkg::OP_OR_LIT
            || instr_reg[15:8] == cise_pkg::OP_MUL_LIT)
            operand_reg <= instr_reg[7:0];
         else if (instr_reg[15:8] == cise_pkg::OP_LOAD_PTR)
            operand_reg <= {6'h00, instr_reg[5:4]}; // pointer number kept for the tail
      end
      else if (phase_reg == cise_pkg::PH_PROCESS && skip_reg == 2'h0 && !secondCycle_reg)
      begin
         if (instr_reg[15:12] == cise_pkg::OP_MOVE_FF)
            result_reg <= accSrc; // source value held for the second cycle
         else if (instr_reg[15:8] == cise_pkg::OP_OR_LIT)
            result_reg <= accumulator | operand_reg;
         else
            result_reg <= fileResult;
         if (instr_reg[15:9] == cise_pkg::OP_MUL_FILE)
            operand_reg <= memRdata;
         pairIsPtr_reg <= instr_reg[15:8] == cise_pkg::OP_LOAD_PTR; // tells the two tails apart
      end
   end

   // -----------------------------------------------------------------
   // data memory requests
   // -----------------------------------------------------------------
   // read strobes in read phase, writes in write phase
   always_ff @(posedge sys_clk)
   begin
      if (rst)
         memReq <= '0;
      else
      begin
         memReq <= '0;
         if (phase_next == cise_pkg::PH_READ && skip_reg == 2'h0)
         begin
            if (secondCycle_reg && !pairIsPtr_reg
               && curWord[15:12] == cise_pkg::OP_SECOND_WORD)
            begin
               memReq.rd <= 1'b1; // dummy read while second word decodes
               memReq.addr <= curWord[11:0];
            end
            else if (curWord[15:12] == cise_pkg::OP_MOVE_FF)
            begin
               memReq.rd <= 1'b1;
               memReq.addr <= curWord[11:0];
            end
            else if (curWord[15:10] == cise_pkg::OP_INC_SKIP_NZ
               || curWord[15:10] == cise_pkg::OP_OR_FILE
               || curWord[15:10] == cise_pkg::OP_MOVE_FILE
               || curWord[15:9] == cise_pkg::OP_STORE_ACC
               || curWord[15:9] == cise_pkg::OP_MUL_FILE)
            begin
               memReq.rd <= 1'b1;
               memReq.addr <= opAddr;
            end
         end
         else if (phase_next == cise_pkg::PH_WRITE && skip_reg == 2'h0)
         begin
            // move to a reserved target is left to software to avoid
            if (secondCycle_reg && instr_reg[15:12] == cise_pkg::OP_SECOND_WORD
               && !pairIsPtr_reg && instr_reg[11:0] != cise_pkg::ACC_ADDR)
            begin
               memReq.wr <= 1'b1;
               memReq.addr <= instr_reg[11:0];
               memReq.wdata <= result_reg;
            end
            else if (!secondCycle_reg && instr_reg[15:9] == cise_pkg::OP_STORE_ACC)
            begin
               memReq.wr <= 1'b1;
               memReq.addr <= opAddr;
               memReq.wdata <= accumulator;
            end
            else if (!secondCycle_reg && instr_reg[9]
               && (instr_reg[15:10] == cise_pkg::OP_INC_SKIP_NZ
               || instr_reg[15:10] == cise_pkg::OP_OR_FILE
               || instr_reg[15:10] == cise_pkg::OP_MOVE_FILE))
            begin
               memReq.wr <= 1'b1;
               memReq.addr <= opAddr;
               memReq.wdata <= fileResult;
            end
         end
      end
   end

   // -----------------------------------------------------------------
   // architectural registers written in the write phase
   // -----------------------------------------------------------------
   // accumulator and flags
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         accumulator <= cise_pkg::RESET_BYTE;
         flags <= '0;
      end
      else if (phase_reg == cise_pkg::PH_WRITE && skip_reg == 2'h0)
      begin
         if (secondCycle_reg)
         begin
            if (instr_reg[15:12] == cise_pkg::OP_SECOND_WORD
               && instr_reg[11:0] == cise_pkg::ACC_ADDR)
               accumulator <= result_reg;
         end
         else if (instr_reg[15:8] == cise_pkg::OP_LOAD_ACC)
            accumulator <= instr_reg[7:0];
         else if (instr_reg[15:8] == cise_pkg::OP_OR_LIT)
         begin
            accumulator <= result_reg;
            flags <= '{neg: result_reg[7], zero: resZero};
         end
         else if (instr_reg[15:10] == cise_pkg::OP_OR_FILE
            || instr_reg[15:10] == cise_pkg::OP_MOVE_FILE)
         begin
            if (!instr_reg[9])
               accumulator <= result_reg;
            flags <= '{neg: result_reg[7], zero: resZero};
         end
         else if (instr_reg[15:10] == cise_pkg::OP_INC_SKIP_NZ && !instr_reg[9])
            accumulator <= result_reg;
      end
   end

   // bank select, products and pointers
   always_ff @(posedge sys_clk)
   begin
      if (rst)
      begin
         bankSelect <= cise_pkg::RESET_BYTE;
         productHigh <= cise_pkg::RESET_BYTE;
         productLow <= cise_pkg::RESET_BYTE;
         pointerRegs <= 36'h0;
      end
      else if (phase_reg == cise_pkg::PH_WRITE && skip_reg == 2'h0)
      begin
         if (!secondCycle_reg && instr_reg[15:8] == cise_pkg::OP_LOAD_BANK)
            bankSelect <= {4'h0, instr_reg[3:0]};
         else if (!secondCycle_reg && (instr_reg[15:8] == cise_pkg::OP_MUL_LIT
            || instr_reg[15:9] == cise_pkg::OP_MUL_FILE))
         begin
            productHigh <= product[15:8]; // flags untouched
            productLow <= product[7:0];
         end
         else if (!secondCycle_reg && instr_reg[15:8] == cise_pkg::OP_LOAD_PTR
            && instr_reg[5:4] != cise_pkg::POINTER_COUNT)
            pointerRegs[instr_reg[5:4]*12 +: 4] <= instr_reg[3:0]; // high part first
         else if (secondCycle_reg && pairIsPtr_reg
            && operand_reg[1:0] != cise_pkg::POINTER_COUNT)
            pointerRegs[operand_reg[1:0]*12 + 4 +: 8] <= instr_reg[7:0];
      end
   end

endmodule

// ---- tb/cise_core_sva.sv ----
// port assertions for the instruction subset executor
`timescale 1ns/1ps
module cise_core_sva
(
   input wire logic sys_clk,
   input wire logic rst,
   input cise_pkg::cise_mem_req_t memReq,
   input wire logic instrTaken,
   input wire logic [7:0] accumulator,
   input wire logic [7:0] bankSelect,
   input wire logic [7:0] productHigh,
   input wire logic [7:0] productLow,
   input cise_pkg::cise_flags_t flags,
   input wire logic [35:0] pointerRegs,
   input wire logic [1:0] skipCount
);
   // ---------
   // phase order and side effects
   // ---------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   // one read and one take per four-phase cycle, a write always two cycles after its read
   sequence noRead3;
      !memReq.rd [*3];
   endsequence
   sequence noWrite4;
      !memReq.wr [*4];
   endsequence
   read_once_a: assert property (memReq.rd |=> noRead3)
      else $error("second read inside one cycle");
   take_once_a: assert property (instrTaken |=> !instrTaken [*3])
      else $error("second take inside one cycle");
   write_after_read_a: assert property (memReq.wr |-> $past(memReq.rd, 2))
      else $error("write without read two cycles before");

   // registers that must not disturb their neighbours when they change
   bank_nibble_a: assert property (bankSelect[7:4] == 4'h0)
      else $error("bank select upper nibble set");
   bank_quiet_a: assert property ($changed(bankSelect) |-> $stable(flags))
      else $error("bank load changed flags");
   mul_keeps_a: assert property ($changed({productHigh, productLow}) |->
      $stable(accumulator) && $stable(flags))
      else $error("multiply touched accumulator or flags");
   ptr_quiet_a: assert property ($changed(pointerRegs) |->
      $stable(flags) && $stable(accumulator) && !memReq.wr)
      else $error("pointer load had side effects");

   // a skip is at most two empty cycles and writes nothing while it runs
   skip_bound_a: assert property (skipCount != 2'h3)
      else $error("skip count beyond two");
   skip_quiet_a: assert property ($rose(skipCount != 2'h0) |-> ##1 noWrite4)
      else $error("write during discarded cycle");
endmodule

bind cise_core cise_core_sva u_sva
(
   .sys_clk(sys_clk),
   .rst(rst),
   .memReq(memReq),
   .instrTaken(instrTaken),
   .accumulator(accumulator),
   .bankSelect(bankSelect),
   .productHigh(productHigh),
   .productLow(productLow),
   .flags(flags),
   .pointerRegs(pointerRegs),
   .skipCount(skipCount)
);

// ---- tb/cise_data_mem.sv ----
// data memory stand-in that answers the executor's read and write requests
`timescale 1ns/1ps
module cise_data_mem
(
   input wire logic sys_clk,
   input cise_pkg::cise_mem_req_t memReq,
   output logic [7:0] memRdata
);
   logic [7:0] mem [0:4095];

   // contents start from an address pattern the bench can predict
   initial
   begin
      for (int i = 0; i < 4096; i++)
         mem[i] = 8'(i) ^ {4'(i >> 8), 4'(i >> 8)} ^ 8'h3c;
      memRdata = 8'h00;
   end

   // data follows a read by one cycle; otherwise the line toggles so stale data never passes
   always @(posedge sys_clk)
   begin
      if (memReq.rd)
         memRdata <= mem[memReq.addr];
      else
         memRdata <= ~memRdata;
      if (memReq.wr)
         mem[memReq.addr] <= memReq.wdata;
   end
endmodule

// ---- tb/tb_cise_core.sv ----
// self-checking bench for the instruction subset executor
`timescale 1ns/1ps
module tb_cise_core;
   // ---------
   // stimulus, watcher and checks
   // ---------
   logic sysClk = 1'b0;
   logic rst = 1'b1;
   logic instrValid = 1'b1;
   logic [15:0] instrWord = 16'h0000;
   logic extendedEnable = 1'b0;
   logic [11:0] pointer2Base = 12'h240;
   logic [7:0] memRdata, accumulator, bankSelect, productHigh, productLow, v, r, f, eAcc, eBsr;
   cise_pkg::cise_mem_req_t memReq;
   cise_pkg::cise_flags_t flags;
   logic instrTaken;
   logic [35:0] pointerRegs;
   logic [1:0] skipCount, eFl;
   logic [11:0] ad, dst, wrA;
   logic [7:0] wrD;
   logic [7:0] sh [0:4095];
   int errors = 0;
   int compares = 0;
   int cycles = 0;
   int wrN = 0;
   int rdN = 0;
   int n0;

   cise_core DUT (.sys_clk(sysClk), .rst(rst), .instrValid(instrValid), .instrWord(instrWord),
      .extendedEnable(extendedEnable), .memRdata(memRdata), .pointer2Base(pointer2Base),
      .memReq(memReq), .instrTaken(instrTaken), .accumulator(accumulator),
      .bankSelect(bankSelect), .productHigh(productHigh), .productLow(productLow),
      .flags(flags), .pointerRegs(pointerRegs), .skipCount(skipCount));
   cise_data_mem farMem (.sys_clk(sysClk), .memReq(memReq), .memRdata(memRdata));

   // clock, bus watcher and a ceiling far above the ~480 cycles the run needs
   always #25 sysClk = ~sysClk;
   always @(posedge sysClk)
   begin
      cycles++;
      rdN += int'(memReq.rd);
      if (memReq.wr)
      begin
         wrN++;
         wrA = memReq.addr;
         wrD = memReq.wdata;
      end
      if (cycles == 3000)
      begin
         errors++;
         conclude();
      end
   end

   // expectations: memory pattern, flag pair and effective address
   function automatic logic [7:0] seed8(input logic [11:0] a);
      return a[7:0] ^ {a[11:8], a[11:8]} ^ 8'h3c;
   endfunction
   function automatic logic [1:0] nz(input logic [7:0] x);
      return {x[7], x == 8'h00};
   endfunction
   function automatic logic [11:0] addrOf(input logic a, input logic [7:0] fa);
      if (a)
         return {eBsr[3:0], fa};
      if (extendedEnable && fa <= cise_pkg::INDEXED_LIMIT)
         return pointer2Base + {4'h0, fa};
      return (fa >= cise_pkg::ACCESS_SPLIT) ? {4'hf, fa} : {4'h0, fa};
   endfunction

   task automatic check(input string name, input logic [35:0] seen, input logic [35:0] exp);
      compares++;
      if (seen !== exp)
      begin
         errors++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wrs(input int n, input int cnt, input logic [11:0] a, input logic [7:0] d);
      check("writes", 36'(wrN - n), 36'(cnt));
      if (cnt > 0)
      begin
         check("wr addr", wrA, a);
         check("wr data", wrD, d);
      end
   endtask
   // one word per four-phase cycle, presented just after the write edge, ahead of the decode edge that takes it
   task automatic issue(input logic [15:0] w);
      instrWord = w;
      repeat (4) @(posedge sysClk);
      #2;
   endtask
   task automatic conclude();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial
   begin
      void'($urandom(32'h5bf7));
      for (int i = 0; i < 4096; i++)
         sh[i] = seed8(12'(i));
      repeat (20) @(posedge sysClk);
      #2;
      rst = 1'b0;
      eFl = 2'b00;
      // literal group: random operands, first pass all zero
      for (int i = 0; i < 12; i++)
      begin
         v = (i == 0) ? 8'h00 : 8'($urandom);
         r = (i == 0) ? 8'h00 : 8'($urandom);
         issue({cise_pkg::OP_LOAD_ACC, v});
         check("acc", accumulator, v);
         check("flags", flags, eFl);
         issue({cise_pkg::OP_MUL_LIT, r});
         check("product", {productHigh, productLow}, 16'(v) * 16'(r));
         check("acc", accumulator, v);
         check("flags", flags, eFl);
         issue({cise_pkg::OP_OR_LIT, r});
         eFl = nz(v | r);
         check("acc", accumulator, v | r);
         check("flags", flags, eFl);
         issue({cise_pkg::OP_LOAD_BANK, r});
         check("bank", bankSelect, {4'h0, r[3:0]});
         check("flags", flags, eFl);
      end
      issue({cise_pkg::OP_LOAD_BANK, 8'hf3});
      eBsr = 8'h03;
      check("bank", bankSelect, eBsr);
      // file group: banked, access low and high, indexed, with the 5f and 60 boundaries
      for (int i = 0; i < 8; i++)
      begin
         extendedEnable = i[2];
         f = i[1] ? (i[2] ? 8'h60 : 8'h60 | 8'($urandom % 32)) :
            (i[2] ? 8'h5f : 8'($urandom % 96));
         ad = addrOf(i[0], f);
         v = 8'($urandom);
         r = v | sh[ad];
         issue({cise_pkg::OP_LOAD_ACC, v});
         n0 = wrN;
         issue({cise_pkg::OP_OR_FILE, 1'b1, i[0], f});
         wrs(n0, 1, ad, r);
         check("acc", accumulator, v);
         check("flags", flags, nz(r));
         sh[ad] = r;
         issue({cise_pkg::OP_MUL_FILE, i[0], f});
         check("product", {productHigh, productLow}, 16'(v) * 16'(r));
         check("acc", accumulator, v);
         issue({cise_pkg::OP_MOVE_FILE, 1'b0, i[0], f});
         wrs(n0, 1, ad, r);
         check("acc", accumulator, r);
         ad = addrOf(i[0], f ^ 8'h01);
         issue({cise_pkg::OP_STORE_ACC, i[0], f ^ 8'h01});
         wrs(n0, 2, ad, r);
         sh[ad] = r;
         check("flags", flags, nz(r));
      end
      eAcc = r;
      eFl = nz(r);
      extendedEnable = 1'b0;
      // skip group: nonzero drops one word or a whole pair; ff wraps to zero and runs on
      for (int i = 0; i < 3; i++)
      begin
         ad = 12'h020 + 12'(i);
         // seed the counter so that only the last pass wraps to zero
         v = (i == 2) ? 8'hff : {1'b0, 7'($urandom)};
         issue({cise_pkg::OP_LOAD_ACC, v});
         issue({cise_pkg::OP_STORE_ACC, 1'b0, ad[7:0]});
         sh[ad] = v;
         r = sh[ad] + 8'h01;
         n0 = wrN;
         issue({cise_pkg::OP_INC_SKIP_NZ, 1'b1, 1'b0, ad[7:0]});
         wrs(n0, 1, ad, r);
         sh[ad] = r;
         if (i == 1)
         begin
            issue({cise_pkg::OP_LOAD_PTR, 8'h05});
            check("skip left", skipCount, 2'h1);
            issue(16'hf0aa);
         end
         else
            issue({cise_pkg::OP_LOAD_ACC, 8'h77});
         eAcc = (i == 2) ? 8'h77 : v;
         check("acc", accumulator, eAcc);
         check("pointers", pointerRegs, 36'h0);
      end
      // pointer group: high part lands with the first word, low byte with the second
      for (int p = 0; p < 3; p++)
      begin
         ad = 12'($urandom);
         issue({cise_pkg::OP_LOAD_PTR, 2'b00, 2'(p), ad[11:8]});
         check("ptr high", pointerRegs[12 * p +: 4], ad[11:8]);
         issue({8'hf0, ad[7:0]});
         check("ptr", pointerRegs[12 * p +: 12], {ad[7:0], ad[11:8]});
         check("flags", flags, eFl);
      end
      // move group: plain, accumulator as source, accumulator as target; no reserved targets
      for (int i = 0; i < 3; i++)
      begin
         ad = (i == 1) ? cise_pkg::ACC_ADDR : 12'h100 | 12'($urandom % 256);
         dst = (i == 2) ? cise_pkg::ACC_ADDR : 12'h3f0 + 12'(i);
         v = (i == 1) ? eAcc : sh[ad];
         n0 = wrN;
         rdN = 0;
         issue({4'hc, ad});
         issue({4'hf, dst});
         check("reads", 36'(rdN), 36'h2);
         check("flags", flags, eFl);
         if (i == 2)
            check("acc", accumulator, v);
         else
            wrs(n0, 1, dst, v);
      end
      conclude();
   end
endmodule
